// [design/lp_ctrl_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the low-power controller
// Assumes: Included by its bare name from the design files
// Notes:   Definitions only
`ifndef LP_CTRL_MAP_SVH
`define LP_CTRL_MAP_SVH

// ======================================================================
// Register offsets (byte addresses)
`define LP_OFS_CTRL       8'h00
`define LP_OFS_WAKE_EN    8'h04
`define LP_OFS_WAKE_QUAL  8'h08
`define LP_OFS_STATUS     8'h0C

// ======================================================================
// Control register fields
`define LP_CTRL_WAIT_REQ   0
`define LP_CTRL_STOP_REQ   1
`define LP_CTRL_PCLK_STOP  2
`define LP_CTRL_XTAL_SEL   3
`define LP_CTRL_DIV8       4
`define LP_CTRL_DIV_LO     5
`define LP_CTRL_DIV_HI     6
`define LP_CTRL_WX_EN      7
`define LP_CTRL_WX_LO      8
`define LP_CTRL_WX_HI      9
`define LP_CTRL_FLASH_STOP 10
`define LP_CTRL_LOWPWR     11
`define LP_CTRL_RESET      12'h010
`define LP_WX_DIV8_CODE    2'h3

// ======================================================================
// Wake qualifier fields
`define LP_QUAL_SER_EXT    0
`define LP_QUAL_RA_EVT_NF  1
`define LP_QUAL_RA_ONCHIP  2
`define LP_QUAL_RB_RA_UF   3
`define LP_QUAL_INT_LO     4
`define LP_QUAL_VM1_FD     8
`define LP_QUAL_VM2_FD     9
`define LP_QUAL_W          10

// ======================================================================
// Interrupt source indices
`define LP_SRC_SERIAL      0
`define LP_SRC_KEY         1
`define LP_SRC_ADC         2
`define LP_SRC_TRA         3
`define LP_SRC_TRB         4
`define LP_SRC_TRC         5
`define LP_SRC_EXT_IRQ_PIN_ZERO        6
`define LP_SRC_VM1         10
`define LP_SRC_VM2         11
`define LP_SRC_OSC_STOP    12
`define LP_SRC_N           13

// ======================================================================
// Wake-up latency in CPU clock cycles
`define LP_LAT_BASE        4
`define LP_LAT_FLASH       12
`define LP_LAT_LOWPWR      16

`endif

// [design/lp_ctrl_pkg.sv]
// Purpose: Types shared by the low-power controller
// Assumes: Nothing
// Notes:   Constants live in lp_ctrl_map.svh
package lp_ctrl_pkg;
   // ======================================================================
   // Power control states
   typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RESUME} pm_state_type;
endpackage

// [design/wake_qualifier.sv]
// Purpose: Decides which pending interrupts may end wait or stop mode
// Assumes: Inputs already synchronised to clk
// Notes:   Pure combinational gating plus checks
`include "lp_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wake_qualifier #(
   parameter int NSRC = `LP_SRC_N
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [NSRC-1:0]         irq_sync,
   input  wire logic [NSRC-1:0]         irq_enable,
   input  wire logic [`LP_QUAL_W-1:0]   qual,
   input  wire logic                    periph_clk_stop_in_wait,
   input  wire logic                    in_wait,
   input  wire logic                    in_stop,
   output logic                         wake
);
   // ======================================================================
   // Usable masks
   logic [NSRC-1:0] ok_wait_run;
   logic [NSRC-1:0] ok_wait_halt;
   logic [NSRC-1:0] ok_stop;
   logic [3:0]      int_nf;
   logic [NSRC-1:0] req;

   initial begin
      if (NSRC != `LP_SRC_N) $error("wake_qualifier: NSRC must equal source count");
   end

   assign int_nf = qual[`LP_QUAL_INT_LO +: 4];
   assign req    = irq_sync & irq_enable;   // Level 000b leaves a source out

   // Peripheral clocks running: everything but the converter
   assign ok_wait_run = ~(13'h1 << `LP_SRC_ADC);

   // Divided clocks halted: only externally or oscillator clocked sources
   assign ok_wait_halt = {1'b0,
                          2'b11,
                          int_nf,
                          1'b0,
                          qual[`LP_QUAL_RB_RA_UF] & qual[`LP_QUAL_RA_ONCHIP],
                          qual[`LP_QUAL_RA_EVT_NF] | qual[`LP_QUAL_RA_ONCHIP],
                          1'b0,
                          1'b1,
                          qual[`LP_QUAL_SER_EXT]};

   // All oscillators halted: only external-signal sources
   assign ok_stop = {1'b0,
                     qual[`LP_QUAL_VM2_FD],
                     qual[`LP_QUAL_VM1_FD],
                     int_nf,
                     2'b00,
                     qual[`LP_QUAL_RA_EVT_NF],
                     1'b0,
                     1'b1,
                     qual[`LP_QUAL_SER_EXT]};

   // Selection by mode
   assign wake = (in_wait & |(req & (periph_clk_stop_in_wait ? ok_wait_halt : ok_wait_run)))
               | (in_stop & |(req & ok_stop));

   // ======================================================================
   // Checks
   property p_adc_never_wakes;
      @(posedge clk) disable iff (rst)
      (req == (13'h1 << `LP_SRC_ADC)) |-> !wake;
   endproperty
   a_adc_never_wakes: assert property (p_adc_never_wakes) else $error("converter woke device");

   property p_stop_filtered_int;
      @(posedge clk) disable iff (rst)
      (in_stop && req == (13'h1 << `LP_SRC_EXT_IRQ_PIN_ZERO) && !int_nf[0]) |-> !wake;
   endproperty
   a_stop_filtered_int: assert property (p_stop_filtered_int) else $error("filtered pin woke stop");

   property p_halt_timer_rc;
      @(posedge clk) disable iff (rst)
      (in_wait && periph_clk_stop_in_wait && req == (13'h1 << `LP_SRC_TRC)) |-> !wake;
   endproperty
   a_halt_timer_rc: assert property (p_halt_timer_rc) else $error("timer RC woke halted wait");
endmodule
`default_nettype wire

// [design/low_power_wait_stop_control.sv]
// Purpose: Wait and stop mode sequencing with wake gating and divider updates
// Assumes: APB master on clk; interrupt pins asynchronous; rst synchronous
// Notes:   Request bits are strobes; stop wins over wait in one cycle
`include "lp_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module low_power_wait_stop_control #(
   parameter int NSRC       = `LP_SRC_N,
   parameter int LAT_BASE   = `LP_LAT_BASE,
   parameter int LAT_FLASH  = `LP_LAT_FLASH,
   parameter int LAT_LOWPWR = `LP_LAT_LOWPWR
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      wait_instr,
   input  wire logic [NSRC-1:0]           periph_irq,
   output logic                           cpu_clk_en,
   output logic                           periph_div_clk_en,
   output logic                           osc_run,
   output logic                           port_hold,
   output logic                           irq_seq_start,
   output logic                           main_div8_select,
   output logic [1:0]                     cpu_div_field,
   output logic                           crystal_output_pin_o,
   output logic                           crystal_output_pin_oe,
   output lp_ctrl_pkg::pm_state_type      pm_state
);
   import lp_ctrl_pkg::*;

   initial begin
      if (NSRC != `LP_SRC_N) $error("NSRC must equal source count");
      if (LAT_BASE < 1 || LAT_BASE + LAT_FLASH + LAT_LOWPWR > 255) $error("latency out of range");
   end

   // ======================================================================
   // Helpers
   function automatic logic [7:0] lat_sel(input logic flash_stop_bit, input logic lowpwr);
      lat_sel = 8'(LAT_BASE) + (flash_stop_bit ? 8'(LAT_FLASH) : 8'h00) + (lowpwr ? 8'(LAT_LOWPWR) : 8'h00);
   endfunction

   // ======================================================================
   // Registers and state
   pm_state_type            state_r;
   pm_state_type            state_nxt;
   logic                    pclk_stop_r;
   logic                    xtal_sel_r;
   logic                    div8_r;
   logic                    div8_nxt;
   logic [1:0]              cpu_div_r;
   logic [1:0]              cpu_div_nxt;
   logic                    wx_en_r;
   logic [1:0]              wx_div_r;
   logic                    flash_stop_r;
   logic                    lowpwr_r;
   logic [NSRC-1:0]         wake_en_r;
   logic [`LP_QUAL_W-1:0]   qual_r;
   logic [7:0]              lat_cnt_r;
   logic [7:0]              lat_cnt_nxt;
   logic                    seq_r;
   logic [31:0]             prdata_r;
   logic [NSRC-1:0]         irq_meta_r;
   logic [NSRC-1:0]         irq_sync_r;
   logic                    wake;

   // ======================================================================
   // APB decode
   logic        acc_wr;
   logic        setup_rd;
   logic        hit;
   logic        wr_ctrl;
   logic        wr_en;
   logic        wr_qual;
   logic        go_wait;
   logic        go_stop;
   logic [31:0] rd_mux;
   logic [31:0] ctrl_view;
   logic [31:0] status_view;

   assign hit      = (paddr == `LP_OFS_CTRL) || (paddr == `LP_OFS_WAKE_EN)
                   || (paddr == `LP_OFS_WAKE_QUAL) || (paddr == `LP_OFS_STATUS);
   assign acc_wr   = psel & penable & pwrite;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign wr_ctrl  = acc_wr & (paddr == `LP_OFS_CTRL);
   assign wr_en    = acc_wr & (paddr == `LP_OFS_WAKE_EN);
   assign wr_qual  = acc_wr & (paddr == `LP_OFS_WAKE_QUAL);
   assign pready   = 1'b1;                 // Zero wait states
   assign pslverr  = psel & penable & ~hit;

   // Request bits are strobes; they read back as zero
   assign go_wait = (state_r == ST_RUN) & (wait_instr | (wr_ctrl & pwdata[`LP_CTRL_WAIT_REQ]));
   assign go_stop = (state_r == ST_RUN) & wr_ctrl & pwdata[`LP_CTRL_STOP_REQ];

   assign ctrl_view = {20'h0, lowpwr_r, flash_stop_r, wx_div_r, wx_en_r, cpu_div_r, div8_r,
                       xtal_sel_r, pclk_stop_r, 2'b00};
   assign status_view = {27'h0, osc_run, periph_div_clk_en, cpu_clk_en, 2'(state_r)};
   assign rd_mux = (paddr == `LP_OFS_CTRL)      ? ctrl_view :
                   (paddr == `LP_OFS_WAKE_EN)   ? {{(32-NSRC){1'b0}}, wake_en_r} :
                   (paddr == `LP_OFS_WAKE_QUAL) ? {{(32-`LP_QUAL_W){1'b0}}, qual_r} :
                   (paddr == `LP_OFS_STATUS)    ? status_view : 32'h0;

   // Read data captured in the setup cycle, shown in the access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_r <= 32'h0;
      end else if (setup_rd) begin
         prdata_r <= rd_mux;
      end
   end
   assign prdata = prdata_r;

   // ======================================================================
   // Interrupt pin synchroniser; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_meta_r <= '0;
         irq_sync_r <= '0;
      end else begin
         irq_meta_r <= periph_irq;
         irq_sync_r <= irq_meta_r;
      end
   end

   wake_qualifier #(
      .NSRC (NSRC)
   ) u_wake (
      .clk                     (clk),
      .rst                     (rst),
      .irq_sync                (irq_sync_r),
      .irq_enable              (wake_en_r),
      .qual                    (qual_r),
      .periph_clk_stop_in_wait (pclk_stop_r),
      .in_wait                 (state_r == ST_WAIT),
      .in_stop                 (state_r == ST_STOP),
      .wake                    (wake)
   );

   // ======================================================================
   // Mode sequencer; reset returns to run from any mode
   always_comb begin
      state_nxt   = state_r;
      div8_nxt    = wr_ctrl ? pwdata[`LP_CTRL_DIV8] : div8_r;
      cpu_div_nxt = wr_ctrl ? pwdata[`LP_CTRL_DIV_HI:`LP_CTRL_DIV_LO] : cpu_div_r;
      lat_cnt_nxt = lat_cnt_r;
      case (state_r)
         ST_RUN: begin
            if (go_stop) begin
               state_nxt = ST_STOP;
               div8_nxt  = 1'b1;
            end else if (go_wait) begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (wake) begin
               state_nxt   = ST_RESUME;
               lat_cnt_nxt = lat_sel(flash_stop_r, lowpwr_r);
               if (wx_en_r) begin
                  div8_nxt    = (wx_div_r == `LP_WX_DIV8_CODE);
                  cpu_div_nxt = (wx_div_r == `LP_WX_DIV8_CODE) ? cpu_div_r : wx_div_r;
               end
            end
         end
         ST_STOP: begin
            if (wake) begin
               state_nxt   = ST_RESUME;
               lat_cnt_nxt = lat_sel(flash_stop_r, lowpwr_r);
            end
         end
         ST_RESUME: begin
            lat_cnt_nxt = lat_cnt_r - 8'h01;
            if (lat_cnt_r == 8'h01) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r   <= ST_RUN;
         div8_r    <= 1'b1;
         cpu_div_r <= 2'b00;
         lat_cnt_r <= 8'h00;
         seq_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         div8_r    <= div8_nxt;
         cpu_div_r <= cpu_div_nxt;
         lat_cnt_r <= lat_cnt_nxt;
         seq_r     <= (state_r == ST_RESUME) && (lat_cnt_r == 8'h01);
      end
   end

   // ======================================================================
   // Software-written configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         pclk_stop_r  <= 1'b0;
         xtal_sel_r   <= 1'b0;
         wx_en_r      <= 1'b0;
         wx_div_r     <= 2'b00;
         flash_stop_r <= 1'b0;
         lowpwr_r     <= 1'b0;
      end else if (wr_ctrl) begin
         pclk_stop_r  <= pwdata[`LP_CTRL_PCLK_STOP];
         xtal_sel_r   <= pwdata[`LP_CTRL_XTAL_SEL];
         wx_en_r      <= pwdata[`LP_CTRL_WX_EN];
         wx_div_r     <= pwdata[`LP_CTRL_WX_HI:`LP_CTRL_WX_LO];
         flash_stop_r <= pwdata[`LP_CTRL_FLASH_STOP];
         lowpwr_r     <= pwdata[`LP_CTRL_LOWPWR];
      end
   end

   // Wake enables stand in for nonzero priority levels
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_en_r <= '0;
         qual_r    <= '0;
      end else begin
         if (wr_en) begin
            wake_en_r <= pwdata[NSRC-1:0];
         end
         if (wr_qual) begin
            qual_r <= pwdata[`LP_QUAL_W-1:0];
         end
      end
   end

   // ======================================================================
   // Clock gating and pin hold
   assign cpu_clk_en        = (state_r == ST_RUN);
   assign osc_run           = (state_r != ST_STOP);
   assign periph_div_clk_en = (state_r == ST_RUN) || (state_r == ST_RESUME)
                            || ((state_r == ST_WAIT) && !pclk_stop_r);
   assign port_hold         = (state_r == ST_WAIT) || (state_r == ST_STOP);
   // Crystal pin: high in stop when selected, else left as input
   assign crystal_output_pin_o  = (state_r == ST_STOP) & xtal_sel_r;
   assign crystal_output_pin_oe = (state_r == ST_STOP) & xtal_sel_r;
   assign irq_seq_start     = seq_r;
   assign main_div8_select  = div8_r;
   assign cpu_div_field     = cpu_div_r;
   assign pm_state          = state_r;

   // ======================================================================
   // Checks
   logic [7:0] resume_len_r;
   logic [7:0] lat_exp_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         resume_len_r <= 8'h00;
         lat_exp_r    <= 8'h00;
      end else if (state_r == ST_RESUME) begin
         resume_len_r <= resume_len_r + 8'h01;
      end else begin
         resume_len_r <= 8'h00;
         lat_exp_r    <= lat_sel(flash_stop_r, lowpwr_r);
      end
   end

   sequence s_stop_req;
      (state_r == ST_RUN) && wr_ctrl && pwdata[`LP_CTRL_STOP_REQ];
   endsequence
   property p_stop_div8;
      @(posedge clk) disable iff (rst)
      s_stop_req |=> (state_r == ST_STOP) && div8_r;
   endproperty
   a_stop_div8: assert property (p_stop_div8) else $error("stop entry lacked divide-by-8");

   property p_stop_clocks;
      @(posedge clk) disable iff (rst)
      (state_r == ST_STOP) |-> !osc_run && !cpu_clk_en && !periph_div_clk_en;
   endproperty
   a_stop_clocks: assert property (p_stop_clocks) else $error("clock ran in stop");

   property p_periph_wait;
      @(posedge clk) disable iff (rst)
      (state_r == ST_WAIT) |-> (periph_div_clk_en == !pclk_stop_r);
   endproperty
   a_periph_wait: assert property (p_periph_wait) else $error("divided clocks wrong in wait");

   property p_wait_exit;
      @(posedge clk) disable iff (rst)
      (state_r == ST_WAIT) && wake |=> (state_r == ST_RESUME);
   endproperty
   a_wait_exit: assert property (p_wait_exit) else $error("wake did not leave wait");

   property p_latency;
      @(posedge clk) disable iff (rst)
      $fell(state_r == ST_RESUME) |-> irq_seq_start && (resume_len_r == lat_exp_r) && cpu_clk_en;
   endproperty
   a_latency: assert property (p_latency) else $error("wake latency mismatch");

   property p_wx_div;
      @(posedge clk) disable iff (rst)
      (state_r == ST_WAIT) && wake && wx_en_r |=> div8_r == ($past(wx_div_r) == `LP_WX_DIV8_CODE);
   endproperty
   a_wx_div: assert property (p_wx_div) else $error("wait exit divider not applied");

   property p_stop_resume_div;
      @(posedge clk) disable iff (rst)
      (state_r == ST_STOP) && wake |=> div8_r [*2];
   endproperty
   a_stop_resume_div: assert property (p_stop_resume_div) else $error("stop exit not divide-by-8");

   property p_crystal_output_pin;
      @(posedge clk) disable iff (rst)
      (state_r == ST_STOP) |-> (crystal_output_pin_oe == xtal_sel_r) && port_hold;
   endproperty
   a_crystal_output_pin: assert property (p_crystal_output_pin) else $error("crystal pin wrong in stop");

   property p_wait_entry;
      @(posedge clk) disable iff (rst)
      (state_r == ST_RUN) && wait_instr && !wr_ctrl |=> (state_r == ST_WAIT);
   endproperty
   a_wait_entry: assert property (p_wait_entry) else $error("wait instruction ignored");
endmodule
`default_nettype wire

// [tb/irq_source_model.sv]
// Purpose: Peripheral interrupt sources facing the controller
// Assumes: Requests are active-high levels
// Notes:   A raised request holds until the interrupt sequence starts
`timescale 1ns/1ps
`default_nettype none
module irq_source_model #(
   parameter int NSRC = 13
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic [NSRC-1:0] raise,
   input  wire logic            serviced,
   output logic [NSRC-1:0]      irq
);
   // ======================================================================
   // Level latch; externally clocked sources keep asserting in stop
   always_ff @(posedge clk) begin
      if (rst || serviced)
         irq <= '0;
      else
         irq <= irq | raise;
   end
endmodule
`default_nettype wire

// [tb/tb_low_power_wait_stop_control.sv]
// Purpose: Self-checking bench for the wait and stop controller
// Assumes: Zero-wait APB slave; APB read data and pslverr sampled at the rising edge, wake loops at the falling edge
// Notes:   Latency parameters left at their defaults
`include "lp_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_low_power_wait_stop_control;
   import lp_ctrl_pkg::*;
   // ======================================================================
   // Signals
   logic         clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wi = 0;
   logic [7:0]   paddr = '0;
   logic [31:0]  pwdata = '0, prdata, rd;
   logic         pready, pslverr, er, cen, pden, osc, hold, seq, div8, xo, xoe;
   logic [1:0]   div;
   logic [12:0]  raise = '0, irq;
   pm_state_type st;
   int           fail_count = 0, samples_checked = 0;

   low_power_wait_stop_control uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wait_instr(wi), .periph_irq(irq), .cpu_clk_en(cen),
      .periph_div_clk_en(pden), .osc_run(osc), .port_hold(hold), .irq_seq_start(seq),
      .main_div8_select(div8), .cpu_div_field(div), .crystal_output_pin_o(xo),
      .crystal_output_pin_oe(xoe), .pm_state(st));
   irq_source_model src (.clk(clk), .rst(rst), .raise(raise), .serviced(seq), .irq(irq));

   // ======================================================================
   // Clock and watchdog; whole run is about a hundred cycles
   initial forever #2 clk = ~clk;
   initial begin
      #20000;
      fail_count++;
      tally_and_finish();
   end

   // ======================================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Setup edge first, so a following call never re-drives psel in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wake(input logic [12:0] s, input int lat);
      int n;
      n = 0;
      @(posedge clk) raise <= s;
      @(posedge clk) raise <= '0;
      while (st !== ST_RESUME && n < 50) begin @(negedge clk); n++; end
      n = 0;
      while (seq !== 1'b1 && n < 50) begin @(negedge clk); n++; end
      chk(n, lat);
      chk({cen, st}, {1'b1, ST_RUN});
      @(posedge clk);
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_stop();
      apb(1, 8'h10, 32'hFFFFFFFF); // unmapped
      chk({er, st}, {1'b1, ST_RUN});
      apb(1, `LP_OFS_WAKE_EN, 32'h003);
      apb(0, `LP_OFS_WAKE_EN, 32'h000);
      chk(rd, 32'h003);
      apb(1, `LP_OFS_WAKE_QUAL, 32'h000);
      apb(1, `LP_OFS_CTRL, 32'h00A);
      @(negedge clk);
      chk({st, osc, cen, div8, xo, xoe, hold}, {ST_STOP, 6'b001111});
      @(posedge clk) raise <= 13'h001;
      @(posedge clk) raise <= '0;
      repeat (8) @(negedge clk);
      chk(st, ST_STOP);
      wake(13'h002, `LP_LAT_BASE);
      chk(div8, 1'b1);
   endtask
   task automatic t_wait();
      apb(1, `LP_OFS_WAKE_EN, 32'h04C);
      apb(1, `LP_OFS_WAKE_QUAL, 32'h010);
      apb(1, `LP_OFS_CTRL, 32'h584);
      @(posedge clk) wi <= 1'b1;
      @(posedge clk) wi <= 1'b0;
      @(posedge clk) raise <= 13'h00C;
      @(posedge clk) raise <= '0;
      repeat (8) @(negedge clk);
      chk({st, pden, cen, hold}, {ST_WAIT, 3'b001});
      wake(13'h040, `LP_LAT_BASE + `LP_LAT_FLASH);
      chk({div8, div}, 3'b001);
   endtask
   task automatic t_rst_wait();
      apb(1, `LP_OFS_CTRL, 32'h001);
      @(negedge clk);
      chk(st, ST_WAIT);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      @(negedge clk);
      chk({st, div8, cen}, {ST_RUN, 2'b11});
      apb(0, `LP_OFS_CTRL, 32'h000);
      chk(rd, 32'h010);
   endtask

   // ======================================================================
   // Sequence and verdict
   task automatic tally_and_finish();
      if (fail_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_stop();
      t_wait();
      t_rst_wait();
      tally_and_finish();
   end
endmodule
`default_nettype wire
